// ===== hw/nis_defs.svh
// constants of the nested interrupt state logic: offsets, fields, resets
`ifndef NIS_DEFS_SVH
`define NIS_DEFS_SVH

// sizes
`define NIS_NUM_IRQ      35
`define NIS_PRIO_W       3
`define NIS_ID_W         6
`define NIS_EVT_W        4

// register byte offsets
`define NIS_OFF_SET_LO   8'h00
`define NIS_OFF_SET_HI   8'h04
`define NIS_OFF_CLR_LO   8'h08
`define NIS_OFF_CLR_HI   8'h0c
`define NIS_OFF_ACT_LO   8'h10
`define NIS_OFF_ACT_HI   8'h14
`define NIS_OFF_MODE_LO  8'h18
`define NIS_OFF_MODE_HI  8'h1c
`define NIS_OFF_TRIG     8'h20
`define NIS_OFF_GROUP    8'h24
`define NIS_OFF_EVT_STAT 8'h28
`define NIS_OFF_EVT_MASK 8'h2c
`define NIS_OFF_PRESENT  8'h30
`define NIS_OFF_PRIO     8'h40

// field positions
`define NIS_PRIO_STRIDE  4
`define NIS_EVT_PEND     0
`define NIS_EVT_ENTER    1
`define NIS_EVT_RET      2
`define NIS_EVT_NMI      3

// reset values
`define NIS_RST_MODE     1'b0
`define NIS_RST_GROUP    2'h0
`define NIS_RST_MASK     4'h0
`define NIS_RST_PRIO     3'h0

`endif

// ===== hw/nis_pkg.sv
// types of the nested interrupt state logic
`include "nis_defs.svh"
package nis_pkg;
   typedef logic [`NIS_PRIO_W-1:0] nis_prio_t;
   typedef logic [`NIS_ID_W-1:0]   nis_id_t;

   // service entry and return as seen from the processor core
   typedef struct packed {
      logic    take;
      nis_id_t take_id;
      logic    ret;
      nis_id_t ret_id;
      logic    nmi_take;
   } nis_core_cmd_t;

   // most urgent interrupt offered to the core
   typedef struct packed {
      logic      valid;
      nis_id_t   id;
      nis_prio_t prio;
   } nis_present_t;
endpackage

// ===== hw/nis_ctrl.sv
// nested interrupt state logic with wishbone register slave
`timescale 1ns/1ns
`include "nis_defs.svh"
module nis_ctrl
   import nis_pkg::*;
#(
   parameter int N = `NIS_NUM_IRQ
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   // peripheral request lines and nmi pin
   input  wire logic [N-1:0]  irq_req_i,
   input  wire logic          nmi_pin_i,
   // processor core side
   input  wire nis_core_cmd_t core_cmd_i,
   output nis_present_t       present_o,
   output logic               nmi_req_o,
   output logic               irq_o
);
   localparam int PW  = `NIS_PRIO_W;
   localparam int PAD = 64 - N;

   ////////////////////////////////////////////////////////////////////
   // declarations
   logic [N-1:0]          pending_r;
   logic [N-1:0]          active_r;
   logic [N-1:0]          line_prev_r;
   logic [N-1:0]          mode_r;
   nis_prio_t             prio_r [N];
   logic [1:0]            group_r;
   logic [`NIS_EVT_W-1:0] evt_stat_r;
   logic [`NIS_EVT_W-1:0] evt_mask_r;
   logic                  irq_r;
   logic                  wb_ack_r;
   logic [31:0]           wb_dat_r;
   nis_present_t          present_r;
   logic                  nmi_s1_r;
   logic                  nmi_s2_r;
   logic                  nmi_s3_r;
   logic                  nmi_lvl_r;
   logic                  nmi_pend_r;

   logic                  wb_go;
   logic                  wr;
   logic                  rd;
   logic [31:0]           lane;
   logic [63:0]           sw_set64;
   logic [63:0]           sw_clr64;
   logic [63:0]           mode_nxt64;
   logic [N-1:0]          sw_set_v;
   logic [N-1:0]          sw_clr_v;
   logic [N-1:0]          rise_v;
   logic [N-1:0]          take_v;
   logic [N-1:0]          ret_v;
   logic [N-1:0]          set_v;
   logic [N-1:0]          clr_v;
   logic [N-1:0]          pend_nxt;
   logic [N-1:0]          active_nxt;
   logic [`NIS_EVT_W-1:0] evt_set;
   logic [`NIS_EVT_W-1:0] evt_stat_nxt;
   logic [31:0]           rd_v;
   logic                  nmi_rise;
   nis_present_t          present_nxt;

   ////////////////////////////////////////////////////////////////////
   // bus decode
   assign wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_r;
   assign wr    = wb_go & wb_we_i;
   assign rd    = wb_go & ~wb_we_i;
   assign lane  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // one-shot write strobes into the pending bank
   always_comb begin
      sw_set64 = '0;
      sw_clr64 = '0;
      if (wr) begin
         case (wb_adr_i)
            `NIS_OFF_SET_LO: sw_set64[31:0]  = wb_dat_i & lane;
            `NIS_OFF_SET_HI: sw_set64[63:32] = wb_dat_i & lane;
            `NIS_OFF_CLR_LO: sw_clr64[31:0]  = wb_dat_i & lane;
            `NIS_OFF_CLR_HI: sw_clr64[63:32] = wb_dat_i & lane;
            // ids at or above N shift out of the used bits
            `NIS_OFF_TRIG: begin
               if (wb_sel_i[0]) begin
                  sw_set64 = 64'h1 << wb_dat_i[`NIS_ID_W-1:0];
               end
            end
            default: begin
               sw_set64 = '0;
            end
         endcase
      end
   end
   assign sw_set_v = sw_set64[N-1:0];
   assign sw_clr_v = sw_clr64[N-1:0];

   always_comb begin
      mode_nxt64 = {{PAD{1'b0}}, mode_r};
      if (wr && wb_adr_i == `NIS_OFF_MODE_LO) begin
         mode_nxt64[31:0] = (mode_nxt64[31:0] & ~lane) | (wb_dat_i & lane);
      end
      if (wr && wb_adr_i == `NIS_OFF_MODE_HI) begin
         mode_nxt64[63:32] = (mode_nxt64[63:32] & ~lane) | (wb_dat_i & lane);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_r <= {N{`NIS_RST_MODE}};
      end else begin
         mode_r <= mode_nxt64[N-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < N; i++) begin
            prio_r[i] <= `NIS_RST_PRIO;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr && wb_adr_i[7:2] == 6'((`NIS_OFF_PRIO >> 2) + i / 8)
                && wb_sel_i[(i % 8) / 2]) begin
               prio_r[i] <= wb_dat_i[(i % 8) * `NIS_PRIO_STRIDE +: PW];
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         group_r    <= `NIS_RST_GROUP;
         evt_mask_r <= `NIS_RST_MASK;
      end else if (wr && wb_sel_i[0]) begin
         if (wb_adr_i == `NIS_OFF_GROUP) begin
            group_r <= wb_dat_i[1:0];
         end
         if (wb_adr_i == `NIS_OFF_EVT_MASK) begin
            evt_mask_r <= wb_dat_i[`NIS_EVT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-interrupt state
   assign rise_v = irq_req_i & ~line_prev_r;
   assign take_v = core_cmd_i.take ? N'(64'h1 << core_cmd_i.take_id) : '0;
   assign ret_v  = core_cmd_i.ret ? N'(64'h1 << core_cmd_i.ret_id) : '0;

   // sets beat clears so no request is lost on a clear cycle
   always_comb begin
      // level high while idle; an entry this cycle must not re-pend
      set_v = irq_req_i & ~active_r & ~mode_r & ~take_v;
      set_v = set_v | rise_v;
      set_v = set_v | sw_set_v;
      // level line still high at return
      set_v = set_v | (ret_v & ~mode_r & irq_req_i);
      clr_v = take_v;
      clr_v = clr_v | (sw_clr_v & (mode_r | ~irq_req_i));
      clr_v = clr_v | (ret_v & ~mode_r);
      pend_nxt   = (pending_r & ~clr_v) | set_v;
      active_nxt = (active_r & ~ret_v) | take_v;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pending_r   <= '0;
         active_r    <= '0;
         line_prev_r <= '0;
      end else begin
         pending_r   <= pend_nxt;
         active_r    <= active_nxt;
         line_prev_r <= irq_req_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // arbitration
   // most urgent, lowest number
   always_comb begin
      nis_prio_t run_grp;
      nis_prio_t best_p;
      nis_id_t   best_id;
      logic      run_any;
      logic      found;
      run_grp = '0;
      best_p  = '0;
      best_id = '0;
      run_any = 1'b0;
      found   = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (active_r[i] && (!run_any || (prio_r[i] >> group_r) < run_grp)) begin
            run_grp = prio_r[i] >> group_r;
            run_any = 1'b1;
         end
      end
      for (int i = N - 1; i >= 0; i--) begin
         if (pending_r[i] && !active_r[i] && (!found || prio_r[i] <= best_p)) begin
            best_p  = prio_r[i];
            best_id = nis_id_t'(i);
            found   = 1'b1;
         end
      end
      // only a more urgent group preempts
      present_nxt.valid = found && (!run_any || (best_p >> group_r) < run_grp);
      present_nxt.id    = best_id;
      present_nxt.prio  = best_p;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         present_r <= '0;
      end else begin
         present_r <= present_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // non-maskable input
   always_ff @(posedge clock) begin
      if (rst) begin
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         nmi_s3_r <= 1'b0;
      end else begin
         nmi_s1_r <= nmi_pin_i;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
      end
   end

   assign nmi_rise = (nmi_s2_r == nmi_s3_r) & nmi_s3_r & ~nmi_lvl_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         nmi_lvl_r  <= 1'b0;
         nmi_pend_r <= 1'b0;
      end else begin
         if (nmi_s2_r == nmi_s3_r) begin
            nmi_lvl_r <= nmi_s3_r;
         end
         nmi_pend_r <= (nmi_pend_r & ~core_cmd_i.nmi_take) | nmi_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event status and interrupt line
   always_comb begin
      evt_set = '0;
      evt_set[`NIS_EVT_PEND]  = |(set_v & ~pending_r);
      evt_set[`NIS_EVT_ENTER] = |take_v;
      evt_set[`NIS_EVT_RET]   = |ret_v;
      evt_set[`NIS_EVT_NMI]   = nmi_rise;
      evt_stat_nxt = evt_stat_r;
      if (rd && wb_adr_i == `NIS_OFF_EVT_STAT) begin
         evt_stat_nxt = '0;
      end
      evt_stat_nxt = evt_stat_nxt | evt_set;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         evt_stat_r <= '0;
         irq_r      <= 1'b0;
      end else begin
         evt_stat_r <= evt_stat_nxt;
         irq_r      <= |(evt_stat_r & evt_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux and acknowledge
   always_comb begin
      logic [63:0] p64;
      logic [63:0] a64;
      p64  = {{PAD{1'b0}}, pending_r};
      a64  = {{PAD{1'b0}}, active_r};
      rd_v = '0;
      case (wb_adr_i)
         `NIS_OFF_SET_LO,
         `NIS_OFF_CLR_LO:   rd_v = p64[31:0];
         `NIS_OFF_SET_HI,
         `NIS_OFF_CLR_HI:   rd_v = p64[63:32];
         `NIS_OFF_ACT_LO:   rd_v = a64[31:0];
         `NIS_OFF_ACT_HI:   rd_v = a64[63:32];
         `NIS_OFF_MODE_LO:  rd_v = mode_nxt64[31:0];
         `NIS_OFF_MODE_HI:  rd_v = mode_nxt64[63:32];
         `NIS_OFF_GROUP:    rd_v[1:0] = group_r;
         `NIS_OFF_EVT_STAT: rd_v[`NIS_EVT_W-1:0] = evt_stat_r;
         `NIS_OFF_EVT_MASK: rd_v[`NIS_EVT_W-1:0] = evt_mask_r;
         `NIS_OFF_PRESENT:  rd_v[15:0] = 16'({present_r.valid, 3'h0,
                                              present_r.id, 1'b0,
                                              present_r.prio});
         default: begin
            for (int i = 0; i < N; i++) begin
               if (wb_adr_i[7:2] == 6'((`NIS_OFF_PRIO >> 2) + i / 8)) begin
                  rd_v[(i % 8) * `NIS_PRIO_STRIDE +: PW] = prio_r[i];
               end
            end
         end
      endcase
   end

   // unmapped addresses still ack, reading zero
   always_ff @(posedge clock) begin
      if (rst) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= '0;
      end else begin
         wb_ack_r <= wb_go;
         if (rd) begin
            wb_dat_r <= rd_v;
         end
      end
   end

   assign wb_ack_o  = wb_ack_r;
   assign wb_dat_o  = wb_dat_r;
   assign present_o = present_r;
   assign nmi_req_o = nmi_pend_r;
   assign irq_o     = irq_r;

   ////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_TAKE_ACTIVE: assert property (
      core_cmd_i.take && core_cmd_i.take_id < N && !core_cmd_i.ret
      |=> active_r[$past(core_cmd_i.take_id)])
      else $error("taken interrupt not active");

   AST_LEVEL_PEND: assert property (
      ##1 (($past(irq_req_i & ~active_r & ~mode_r & ~take_v) & ~pending_r) == '0))
      else $error("high idle level line not pending");

   AST_RISE_PEND: assert property (
      ##1 (($past(irq_req_i & ~line_prev_r) & ~pending_r) == '0))
      else $error("rising request not pending");

   AST_SW_SET: assert property (
      ##1 (($past(sw_set_v) & ~pending_r) == '0))
      else $error("software set lost");

   AST_RET_LEVEL: assert property (
      core_cmd_i.ret && core_cmd_i.ret_id < N
      && !mode_r[core_cmd_i.ret_id] && irq_req_i[core_cmd_i.ret_id]
      |=> pending_r[$past(core_cmd_i.ret_id)])
      else $error("level return with line high not pending");

   AST_RET_INACT: assert property (
      core_cmd_i.ret && !core_cmd_i.take && core_cmd_i.ret_id < N
      |=> !active_r[$past(core_cmd_i.ret_id)])
      else $error("returned interrupt still active");

   AST_CLR_LEVEL: assert property (
      ##1 (($past(sw_clr_v & ~mode_r & irq_req_i & pending_r & ~take_v
               & ~ret_v) & ~pending_r) == '0))
      else $error("level clear took effect with line high");

   AST_CLR_PULSE: assert property (
      ##1 (($past(sw_clr_v & mode_r & ~set_v) & pending_r) == '0))
      else $error("pulse clear-pending ignored");

   AST_PRESENT: assert property (
      present_r.valid |-> |($past(pending_r & ~active_r) & (N'(1) << present_r.id)))
      else $error("presented interrupt was not pending");

   // nmi within one cycle of agreed edge
   AST_NMI: assert property (
      nmi_rise |=> nmi_req_o)
      else $error("nmi edge not latched");

   AST_WB_ACK: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   AST_IRQ_OUT: assert property (
      ##1 (irq_o == $past(|(evt_stat_r & evt_mask_r))))
      else $error("interrupt output disagrees with status");

   COV_TAKE_RET: cover property (
      core_cmd_i.take ##[1:20] core_cmd_i.ret);
   COV_ACT_PEND: cover property (
      |(active_r & pending_r & mode_r));
   COV_NMI: cover property (
      nmi_rise ##[1:10] core_cmd_i.nmi_take);
   COV_PREEMPT: cover property (
      present_r.valid && |active_r);
endmodule // nis_ctrl

// ===== tb/nis_periph_model.sv
// peripheral request line model for the nested interrupt state logic
`timescale 1ns/1ns
module nis_periph_model #(
   parameter int N = 35
) (
   // clock
   input  wire logic         clock,
   // requests from the bench
   input  wire logic [N-1:0] lvl_on,
   input  wire logic [N-1:0] pls_go,
   input  wire logic         slow,
   // request lines towards the controller
   output logic      [N-1:0] irq_req
);
   logic [N-1:0] lvl_r;
   logic [N-1:0] pls_r;
   logic [N-1:0] pls_hold_r;

   ////////////////////////////////////////////////////////////////////////////////
   // level held
   // level line stays up until the bench withdraws it after service
   always_ff @(posedge clock) begin
      lvl_r <= lvl_on;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pulse width
   // one full cycle at least; slow peripherals stretch to two
   always_ff @(posedge clock) begin
      pls_r      <= pls_go | (slow ? pls_hold_r : '0);
      pls_hold_r <= pls_go;
   end

   assign irq_req = lvl_r | pls_r;
endmodule // nis_periph_model

// ===== tb/nis_ctrl_tb.sv
// self-checking bench of the nested interrupt state logic
`timescale 1ns/1ns
`include "nis_defs.svh"
module nis_ctrl_tb
   import nis_pkg::*;
;
   localparam int N = `NIS_NUM_IRQ;
   typedef struct packed {
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [7:0]  ra;
      logic [31:0] exp;
   } nis_row_t;

   logic          clock = 1'b0;
   logic          rst = 1'b1;
   logic          cyc = 1'b0;
   logic          stb = 1'b0;
   logic          we = 1'b0;
   logic [7:0]    adr = 8'h00;
   logic [3:0]    sel = 4'hf;
   logic [31:0]   wdat = 32'h0;
   logic [31:0]   rdat;
   logic          ack;
   logic [N-1:0]  irq_req;
   logic [N-1:0]  lvl = '0;
   logic [N-1:0]  pls = '0;
   logic          slow = 1'b0;
   logic          nmi = 1'b0;
   nis_core_cmd_t core_cmd = '0;
   nis_present_t  present;
   logic          nmi_req;
   logic          irq;
   int            n_fail = 0;
   int            tests_run = 0;
   logic [31:0]   q;
   nis_row_t      rows [11];

   initial begin
      forever #10 clock = ~clock;
   end

   nis_ctrl #(.N(N)) i_nis_ctrl (
      .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_req_i(irq_req), .nmi_pin_i(nmi), .core_cmd_i(core_cmd), .present_o(present),
      .nmi_req_o(nmi_req), .irq_o(irq)
   );

   nis_periph_model #(.N(N)) i_nis_periph_model (
      .clock(clock), .lvl_on(lvl), .pls_go(pls), .slow(slow), .irq_req(irq_req)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // holds the request until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         n_fail++;
         $display("mismatch ack expected 1 seen %b", ack);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask

   task automatic core(input logic tk, input logic rt, input logic nm, input logic [5:0] id);
      nis_core_cmd_t c;
      c = '0;
      c.take = tk;
      c.take_id = id;
      c.ret = rt;
      c.ret_id = id;
      c.nmi_take = nm;
      @(posedge clock);
      core_cmd <= c;
      @(posedge clock);
      core_cmd <= '0;
   endtask

   task automatic pulse(input int id);
      @(posedge clock);
      pls[id] <= 1'b1;
      @(posedge clock);
      pls <= '0;
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_sim();
   end

   initial begin
      rows[0]  = '{`NIS_OFF_SET_LO, 32'h0000_0011, `NIS_OFF_SET_LO, 32'h0000_0011};
      rows[1]  = '{`NIS_OFF_CLR_LO, 32'h0000_0011, `NIS_OFF_SET_LO, 32'h0000_0000};
      rows[2]  = '{`NIS_OFF_TRIG, 32'h0000_0022, `NIS_OFF_SET_HI, 32'h0000_0004};
      rows[3]  = '{`NIS_OFF_CLR_HI, 32'h0000_0004, `NIS_OFF_SET_HI, 32'h0000_0000};
      rows[4]  = '{`NIS_OFF_TRIG, 32'h0000_0023, `NIS_OFF_SET_HI, 32'h0000_0000};
      rows[5]  = '{`NIS_OFF_MODE_HI, 32'h0000_0007, `NIS_OFF_MODE_HI, 32'h0000_0007};
      rows[6]  = '{`NIS_OFF_MODE_HI, 32'h0000_0000, `NIS_OFF_MODE_HI, 32'h0000_0000};
      rows[7]  = '{`NIS_OFF_GROUP, 32'h0000_0002, `NIS_OFF_GROUP, 32'h0000_0002};
      rows[8]  = '{`NIS_OFF_GROUP, 32'h0000_0000, `NIS_OFF_GROUP, 32'h0000_0000};
      rows[9]  = '{8'h3c, 32'hffff_ffff, 8'h3c, 32'h0000_0000};
      rows[10] = '{`NIS_OFF_ACT_LO, 32'hffff_ffff, `NIS_OFF_ACT_LO, 32'h0000_0000};
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      // reset values
      chk("irq", {31'h0, irq}, 32'h0);
      chk("present", {22'h0, present}, 32'h0);
      rd("mode", `NIS_OFF_MODE_LO, 32'h0);
      rd("mask", `NIS_OFF_EVT_MASK, 32'h0);
      rd("prio", `NIS_OFF_PRIO, 32'h0);
      done("reset");
      foreach (rows[i]) begin
         wb(1'b1, rows[i].wa, rows[i].wd);
         rd("row", rows[i].ra, rows[i].exp);
      end
      done("table");
      // level line through entry and return
      @(posedge clock);
      lvl[5] <= 1'b1;
      repeat (4) @(posedge clock);
      chk("present", {22'h0, present}, {22'h0, 1'b1, 6'd5, 3'd0});
      core(1'b1, 1'b0, 1'b0, 6'd5);
      rd("act", `NIS_OFF_ACT_LO, 32'h20);
      rd("pend", `NIS_OFF_SET_LO, 32'h0);
      core(1'b0, 1'b1, 1'b0, 6'd5);
      rd("pend", `NIS_OFF_SET_LO, 32'h20);
      core(1'b1, 1'b0, 1'b0, 6'd5);
      lvl[5] <= 1'b0;
      repeat (3) @(posedge clock);
      core(1'b0, 1'b1, 1'b0, 6'd5);
      rd("pend", `NIS_OFF_SET_LO, 32'h0);
      rd("act", `NIS_OFF_ACT_LO, 32'h0);
      done("level");
      // pulse line, slow peripheral first
      wb(1'b1, `NIS_OFF_MODE_LO, 32'h8);
      slow <= 1'b1;
      pulse(3);
      rd("pend", `NIS_OFF_SET_LO, 32'h8);
      slow <= 1'b0;
      core(1'b1, 1'b0, 1'b0, 6'd3);
      pulse(3);
      rd("pend", `NIS_OFF_SET_LO, 32'h8);
      rd("act", `NIS_OFF_ACT_LO, 32'h8);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h8);
      rd("pend", `NIS_OFF_SET_LO, 32'h0);
      rd("act", `NIS_OFF_ACT_LO, 32'h8);
      pulse(3);
      core(1'b0, 1'b1, 1'b0, 6'd3);
      rd("pend", `NIS_OFF_SET_LO, 32'h8);
      rd("act", `NIS_OFF_ACT_LO, 32'h0);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h8);
      rd("pend", `NIS_OFF_SET_LO, 32'h0);
      pulse(3);
      core(1'b1, 1'b0, 1'b0, 6'd3);
      core(1'b0, 1'b1, 1'b0, 6'd3);
      rd("pend", `NIS_OFF_SET_LO, 32'h0);
      rd("act", `NIS_OFF_ACT_LO, 32'h0);
      wb(1'b1, `NIS_OFF_MODE_LO, 32'h0);
      done("pulse");
      // level clear-pending while line high
      @(posedge clock);
      lvl[7] <= 1'b1;
      repeat (3) @(posedge clock);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h80);
      rd("pend", `NIS_OFF_SET_LO, 32'h80);
      lvl[7] <= 1'b0;
      repeat (3) @(posedge clock);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h80);
      rd("pend", `NIS_OFF_SET_LO, 32'h0);
      done("clear");
      // priority order, tie to lowest number
      wb(1'b1, `NIS_OFF_PRIO, 32'h0000_0250);
      wb(1'b1, `NIS_OFF_PRIO + 8'h04, 32'h0000_0020);
      wb(1'b1, `NIS_OFF_SET_LO, 32'h0000_0206);
      rd("best", `NIS_OFF_PRESENT, 32'h0000_2022);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h0000_0204);
      rd("best", `NIS_OFF_PRESENT, 32'h0000_2015);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h0000_0002);
      // group split: only a strictly more urgent group preempts
      core(1'b1, 1'b0, 1'b0, 6'd2);
      wb(1'b1, `NIS_OFF_SET_LO, 32'h1);
      rd("grp", `NIS_OFF_PRESENT, 32'h0000_2000);
      wb(1'b1, `NIS_OFF_GROUP, 32'h2);
      rd("grp", `NIS_OFF_PRESENT, 32'h0000_0000);
      core(1'b0, 1'b1, 1'b0, 6'd2);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h1);
      wb(1'b1, `NIS_OFF_GROUP, 32'h0);
      done("priority");
      // event status, mask and interrupt output
      wb(1'b0, `NIS_OFF_EVT_STAT, 32'h0);
      wb(1'b1, `NIS_OFF_EVT_MASK, 32'h1);
      wb(1'b1, `NIS_OFF_SET_LO, 32'h1);
      repeat (3) @(posedge clock);
      chk("irq", {31'h0, irq}, 32'h1);
      rd("evt", `NIS_OFF_EVT_STAT, 32'h1);
      repeat (3) @(posedge clock);
      chk("irq", {31'h0, irq}, 32'h0);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h1);
      wb(1'b1, `NIS_OFF_EVT_MASK, 32'h0);
      wb(1'b1, `NIS_OFF_SET_LO, 32'h2);
      repeat (3) @(posedge clock);
      chk("irq", {31'h0, irq}, 32'h0);
      rd("evt", `NIS_OFF_EVT_STAT, 32'h1);
      wb(1'b1, `NIS_OFF_CLR_LO, 32'h2);
      done("events");
      // non-maskable input through the synchroniser
      @(posedge clock);
      nmi <= 1'b1;
      for (int i = 0; i < 10 && nmi_req !== 1'b1; i++) begin
         @(posedge clock);
      end
      chk("nmi", {31'h0, nmi_req}, 32'h1);
      core(1'b0, 1'b0, 1'b1, 6'd0);
      @(posedge clock);
      chk("nmi", {31'h0, nmi_req}, 32'h0);
      nmi <= 1'b0;
      done("nmi");
      end_sim();
   end
endmodule // nis_ctrl_tb
